/* verilog/gpio_pkg.sv */
// Notes on behaviour
// - Direction one tri-states peripheral port pin
// - Direction zero drives pin from latch
// - Enabled peripheral forces pin direction
// - Bits 0-2 carry timer and capture channels
// - Bits 3-7 carry serial and USART signals
// - Slave port pins each have direction bit
// - Mode bit turns port into slave port
// - Slave pin n carries data bit n
// - Control pins settable; strobes in slave mode
// - Analog control pin reads back zero
// - Direction bits still drive analog pins
// - Power-on makes control pins analog
// - Reset sets peripheral direction all ones
// - Reset sets slave direction all ones
// - Control register resets to 0000 -111
// - Mode off clears buffer flags, keeps overrun
`default_nettype none
package gpio_pkg;
	localparam int ADDR_W = 8;
	localparam int DATA_W = 8;
	localparam int CTRL_W = 3;
	localparam logic [7:0] PERIPH_DATA_ADDR = 8'h07;
	localparam logic [7:0] SLAVE_DATA_ADDR = 8'h08;
	localparam logic [7:0] CTRL_DATA_ADDR = 8'h09;
	localparam logic [7:0] PERIPH_DIR_ADDR = 8'h87;
	localparam logic [7:0] SLAVE_DIR_ADDR = 8'h88;
	localparam logic [7:0] CTRL_DIR_MODE_ADDR = 8'h89;
	localparam logic [7:0] ANALOG_CFG_ADDR = 8'h9f;
	localparam logic [7:0] PERIPH_DIR_RESET = 8'hff;
	localparam logic [7:0] SLAVE_DIR_RESET = 8'hff;
	localparam logic [7:0] CTRL_DIR_MODE_RESET = 8'h07;
	localparam logic [7:0] DATA_LATCH_RESET = 8'h00;
	localparam logic [2:0] ANALOG_CFG_RESET = 3'h0;
	// Field positions of the control direction and mode register
	localparam int WAITING_BIT = 7;
	localparam int PENDING_BIT = 6;
	localparam int OVERRUN_BIT = 5;
	localparam int MODE_BIT = 4;
	// Peripheral pin roles on the multiplexed port
	localparam int TIMER_CLK_BIT = 0;
	localparam int TIMER_OSC_CCP2_BIT = 1;
	localparam int CCP1_BIT = 2;
	localparam int SERIAL_CLK_BIT = 3;
	localparam int SERIAL_DIN_BIT = 4;
	localparam int SERIAL_DOUT_BIT = 5;
	localparam int USART_TX_BIT = 6;
	localparam int USART_RX_BIT = 7;
	// Control pin roles in slave mode
	localparam int READ_STROBE_BIT = 0;
	localparam int WRITE_STROBE_BIT = 1;
	localparam int CHIP_SELECT_BIT = 2;
	typedef enum logic [2:0] {
		SEL_NONE = 3'b000,
		SEL_PERIPH_DATA = 3'b001,
		SEL_SLAVE_DATA = 3'b010,
		SEL_CTRL_DATA = 3'b011,
		SEL_PERIPH_DIR = 3'b100,
		SEL_SLAVE_DIR = 3'b101,
		SEL_CTRL_DIR = 3'b110,
		SEL_ANALOG = 3'b111
	} reg_sel_type;
endpackage
`default_nettype wire

/* verilog/sync_two_stage.sv */
`timescale 1ns/1ps
`default_nettype none
module sync_two_stage #(
	parameter int WIDTH = 8
) (
	input wire logic sys_clk_in,
	input wire logic rst_in,
	input wire logic [WIDTH-1:0] async_in,
	output logic [WIDTH-1:0] sync_out
);
	logic [WIDTH-1:0] meta_reg;

	// First stage feeds only the second
	always_ff @(posedge sys_clk_in or posedge rst_in) begin
		if (rst_in) begin
			meta_reg <= '0;
			sync_out <= '0;
		end else begin
			meta_reg <= async_in;
			sync_out <= meta_reg;
		end
	end
endmodule
`default_nettype wire

/* verilog/pin_driver.sv */
`timescale 1ns/1ps
`default_nettype none
module pin_driver #(
	parameter int WIDTH = 8
) (
	input wire logic sys_clk_in,
	input wire logic rst_in,
	input wire logic [WIDTH-1:0] latch_in,
	input wire logic [WIDTH-1:0] dir_in,
	input wire logic [WIDTH-1:0] force_out_in,
	input wire logic [WIDTH-1:0] force_in_in,
	input wire logic [WIDTH-1:0] alt_data_in,
	output logic [WIDTH-1:0] pin_out,
	output logic [WIDTH-1:0] pin_oe_out
);
	genvar i;
	generate
		for (i = 0; i < WIDTH; i++) begin : g_bit
			always_ff @(posedge sys_clk_in or posedge rst_in) begin
				if (rst_in) begin
					pin_out[i] <= 1'b0;
					pin_oe_out[i] <= 1'b0;
				end else if (force_out_in[i]) begin
					pin_out[i] <= alt_data_in[i];
					pin_oe_out[i] <= 1'b1;
				end else if (force_in_in[i]) begin
					pin_out[i] <= latch_in[i];
					pin_oe_out[i] <= 1'b0;
				end else begin
					pin_out[i] <= latch_in[i];
					pin_oe_out[i] <= ~dir_in[i];
				end
			end
		end
	endgenerate
endmodule
`default_nettype wire

/* verilog/three_port_gpio_block.sv */
`timescale 1ns/1ps
`default_nettype none
module three_port_gpio_block (
	input wire logic sys_clk_in,
	input wire logic rst_in,
	input wire logic other_rst_in,
	input wire logic [gpio_pkg::ADDR_W-1:0] addr_in,
	input wire logic [gpio_pkg::DATA_W-1:0] wr_data_in,
	input wire logic wr_en_in,
	input wire logic rd_en_in,
	output logic [gpio_pkg::DATA_W-1:0] rd_data_out,
	input wire logic [7:0] periph_pin_in,
	output logic [7:0] periph_pin_out,
	output logic [7:0] periph_pin_oe_out,
	input wire logic [7:0] periph_force_out_in,
	input wire logic [7:0] periph_force_in_in,
	input wire logic [7:0] periph_data_in,
	output logic [7:0] periph_pin_level_out,
	input wire logic [7:0] slave_pin_in,
	output logic [7:0] slave_pin_out,
	output logic [7:0] slave_pin_oe_out,
	input wire logic [gpio_pkg::CTRL_W-1:0] ctrl_pin_in,
	output logic [gpio_pkg::CTRL_W-1:0] ctrl_pin_out,
	output logic [gpio_pkg::CTRL_W-1:0] ctrl_pin_oe_out,
	output logic slave_mode_select_out,
	output logic [7:0] slave_bus_level_out,
	output logic read_strobe_n_out,
	output logic write_strobe_n_out,
	output logic chip_select_n_out,
	input wire logic slave_bus_drive_in,
	input wire logic [7:0] slave_input_latch_in,
	input wire logic word_received_in,
	input wire logic word_taken_in,
	output logic [7:0] slave_output_latch_out,
	output logic [gpio_pkg::CTRL_W-1:0] analog_select_out
);
	import gpio_pkg::*;

	logic [7:0] periph_latch_reg;
	logic [7:0] slave_latch_reg;
	logic [CTRL_W-1:0] ctrl_latch_reg;
	logic [7:0] periph_dir_reg;
	logic [7:0] slave_dir_reg;
	logic [CTRL_W-1:0] ctrl_dir_reg;
	logic slave_mode_reg;
	logic waiting_reg;
	logic pending_reg;
	logic overrun_reg;
	logic [CTRL_W-1:0] digital_cfg_reg;
	logic [7:0] periph_sync;
	logic [7:0] slave_sync;
	logic [CTRL_W-1:0] ctrl_sync;
	logic [7:0] rd_next;
	logic [7:0] ctrl_dir_mode_view;
	logic [7:0] slave_force_out;
	logic [7:0] slave_force_in;
	logic [CTRL_W-1:0] analog_mask;
	logic wr_periph_data;
	logic wr_slave_data;
	logic wr_ctrl_data;
	logic wr_periph_dir;
	logic wr_slave_dir;
	logic wr_ctrl_dir;
	logic wr_analog;
	logic rd_slave_data;

	function automatic reg_sel_type decode(input logic [7:0] addr);
		unique case (addr)
			PERIPH_DATA_ADDR: decode = SEL_PERIPH_DATA;
			SLAVE_DATA_ADDR: decode = SEL_SLAVE_DATA;
			CTRL_DATA_ADDR: decode = SEL_CTRL_DATA;
			PERIPH_DIR_ADDR: decode = SEL_PERIPH_DIR;
			SLAVE_DIR_ADDR: decode = SEL_SLAVE_DIR;
			CTRL_DIR_MODE_ADDR: decode = SEL_CTRL_DIR;
			ANALOG_CFG_ADDR: decode = SEL_ANALOG;
			default: decode = SEL_NONE;
		endcase
	endfunction

	// Pins come from outside the clock domain
	sync_two_stage #(
		.WIDTH(8)
	) u_periph_sync (
		.sys_clk_in(sys_clk_in),
		.rst_in(rst_in),
		.async_in(periph_pin_in),
		.sync_out(periph_sync)
	);

	sync_two_stage #(
		.WIDTH(8)
	) u_slave_sync (
		.sys_clk_in(sys_clk_in),
		.rst_in(rst_in),
		.async_in(slave_pin_in),
		.sync_out(slave_sync)
	);

	sync_two_stage #(
		.WIDTH(CTRL_W)
	) u_ctrl_sync (
		.sys_clk_in(sys_clk_in),
		.rst_in(rst_in),
		.async_in(ctrl_pin_in),
		.sync_out(ctrl_sync)
	);

	// Write strobes per register
	always_comb begin
		wr_periph_data = wr_en_in && decode(addr_in) == SEL_PERIPH_DATA;
		wr_slave_data = wr_en_in && decode(addr_in) == SEL_SLAVE_DATA;
		wr_ctrl_data = wr_en_in && decode(addr_in) == SEL_CTRL_DATA;
		wr_periph_dir = wr_en_in && decode(addr_in) == SEL_PERIPH_DIR;
		wr_slave_dir = wr_en_in && decode(addr_in) == SEL_SLAVE_DIR;
		wr_ctrl_dir = wr_en_in && decode(addr_in) == SEL_CTRL_DIR;
		wr_analog = wr_en_in && decode(addr_in) == SEL_ANALOG;
		rd_slave_data = rd_en_in && decode(addr_in) == SEL_SLAVE_DATA;
	end

	// Data latches survive warm resets; only power-on clears them
	always_ff @(posedge sys_clk_in or posedge rst_in) begin
		if (rst_in) begin
			periph_latch_reg <= DATA_LATCH_RESET;
			slave_latch_reg <= DATA_LATCH_RESET;
			ctrl_latch_reg <= DATA_LATCH_RESET[CTRL_W-1:0];
		end else begin
			if (wr_periph_data) begin
				periph_latch_reg <= wr_data_in;
			end
			if (wr_slave_data) begin
				slave_latch_reg <= wr_data_in;
			end
			if (wr_ctrl_data) begin
				ctrl_latch_reg <= wr_data_in[CTRL_W-1:0];
			end
		end
	end

	// Direction registers return to all inputs on every reset
	always_ff @(posedge sys_clk_in or posedge rst_in) begin
		if (rst_in) begin
			periph_dir_reg <= PERIPH_DIR_RESET;
			slave_dir_reg <= SLAVE_DIR_RESET;
		end else if (other_rst_in) begin
			periph_dir_reg <= PERIPH_DIR_RESET;
			slave_dir_reg <= SLAVE_DIR_RESET;
		end else begin
			if (wr_periph_dir) begin
				periph_dir_reg <= wr_data_in;
			end
			if (wr_slave_dir) begin
				slave_dir_reg <= wr_data_in;
			end
		end
	end

	// Mode and control pin direction
	always_ff @(posedge sys_clk_in or posedge rst_in) begin
		if (rst_in) begin
			slave_mode_reg <= CTRL_DIR_MODE_RESET[MODE_BIT];
			ctrl_dir_reg <= CTRL_DIR_MODE_RESET[CTRL_W-1:0];
		end else if (other_rst_in) begin
			slave_mode_reg <= CTRL_DIR_MODE_RESET[MODE_BIT];
			ctrl_dir_reg <= CTRL_DIR_MODE_RESET[CTRL_W-1:0];
		end else if (wr_ctrl_dir) begin
			slave_mode_reg <= wr_data_in[MODE_BIT];
			ctrl_dir_reg <= wr_data_in[CTRL_W-1:0];
		end
	end

	// Input word waiting: set by a finished external write
	always_ff @(posedge sys_clk_in or posedge rst_in) begin
		if (rst_in) begin
			waiting_reg <= CTRL_DIR_MODE_RESET[WAITING_BIT];
		end else if (other_rst_in) begin
			waiting_reg <= CTRL_DIR_MODE_RESET[WAITING_BIT];
		end else if (!slave_mode_reg) begin
			waiting_reg <= 1'b0;
		end else if (word_received_in) begin
			waiting_reg <= 1'b1;
		end else if (rd_slave_data) begin
			waiting_reg <= 1'b0;
		end
	end

	// Output word pending: firmware writes set, external read clears
	always_ff @(posedge sys_clk_in or posedge rst_in) begin
		if (rst_in) begin
			pending_reg <= CTRL_DIR_MODE_RESET[PENDING_BIT];
		end else if (other_rst_in) begin
			pending_reg <= CTRL_DIR_MODE_RESET[PENDING_BIT];
		end else if (!slave_mode_reg) begin
			pending_reg <= 1'b0;
		end else if (word_taken_in) begin
			// A write during an external read leaves it clear
			pending_reg <= 1'b0;
		end else if (wr_slave_data) begin
			pending_reg <= 1'b1;
		end
	end

	// Overrun keeps its value outside slave mode; set beats clear
	always_ff @(posedge sys_clk_in or posedge rst_in) begin
		if (rst_in) begin
			overrun_reg <= CTRL_DIR_MODE_RESET[OVERRUN_BIT];
		end else if (other_rst_in) begin
			overrun_reg <= CTRL_DIR_MODE_RESET[OVERRUN_BIT];
		end else if (slave_mode_reg && word_received_in && waiting_reg) begin
			overrun_reg <= 1'b1;
		end else if (wr_ctrl_dir) begin
			overrun_reg <= wr_data_in[OVERRUN_BIT];
		end
	end

	// Analog selection: a set bit makes that control pin digital
	always_ff @(posedge sys_clk_in or posedge rst_in) begin
		if (rst_in) begin
			digital_cfg_reg <= ANALOG_CFG_RESET;
		end else if (other_rst_in) begin
			digital_cfg_reg <= ANALOG_CFG_RESET;
		end else if (wr_analog) begin
			digital_cfg_reg <= wr_data_in[CTRL_W-1:0];
		end
	end

	always_comb begin
		analog_mask = ~digital_cfg_reg;
		// Bit 3 is unimplemented and reads zero
		ctrl_dir_mode_view = {waiting_reg, pending_reg, overrun_reg,
			slave_mode_reg, 1'b0, ctrl_dir_reg};
		// External bus owns slave pin direction in slave mode
		slave_force_out = {8{slave_mode_reg && slave_bus_drive_in}};
		slave_force_in = {8{slave_mode_reg && !slave_bus_drive_in}};
	end

	// Read mux, answered one cycle after the strobe
	always_comb begin
		rd_next = 8'h00;
		unique case (decode(addr_in))
			SEL_PERIPH_DATA: rd_next = periph_sync;
			SEL_SLAVE_DATA: begin
				if (slave_mode_reg) begin
					rd_next = slave_input_latch_in;
				end else begin
					rd_next = slave_sync;
				end
			end
			SEL_CTRL_DATA: begin
				rd_next = {5'h00, ctrl_sync & ~analog_mask};
			end
			// Stored setting, not the peripheral override
			SEL_PERIPH_DIR: rd_next = periph_dir_reg;
			SEL_SLAVE_DIR: rd_next = slave_dir_reg;
			SEL_CTRL_DIR: rd_next = ctrl_dir_mode_view;
			SEL_ANALOG: rd_next = {5'h00, digital_cfg_reg};
			SEL_NONE: rd_next = 8'h00;
		endcase
	end

	always_ff @(posedge sys_clk_in or posedge rst_in) begin
		if (rst_in) begin
			rd_data_out <= 8'h00;
		end else if (rd_en_in) begin
			rd_data_out <= rd_next;
		end else begin
			rd_data_out <= 8'h00;
		end
	end

	// Peripheral port: overrides win over stored direction
	pin_driver #(
		.WIDTH(8)
	) u_periph_drv (
		.sys_clk_in(sys_clk_in),
		.rst_in(rst_in),
		.latch_in(periph_latch_reg),
		.dir_in(periph_dir_reg),
		.force_out_in(periph_force_out_in),
		.force_in_in(periph_force_in_in),
		.alt_data_in(periph_data_in),
		.pin_out(periph_pin_out),
		.pin_oe_out(periph_pin_oe_out)
	);

	// Slave port: direction register ignored in slave mode
	pin_driver #(
		.WIDTH(8)
	) u_slave_drv (
		.sys_clk_in(sys_clk_in),
		.rst_in(rst_in),
		.latch_in(slave_latch_reg),
		.dir_in(slave_dir_reg),
		.force_out_in(slave_force_out),
		.force_in_in(slave_force_in),
		.alt_data_in(slave_latch_reg),
		.pin_out(slave_pin_out),
		.pin_oe_out(slave_pin_oe_out)
	);

	// Direction still rules in analog mode; software keeps inputs
	pin_driver #(
		.WIDTH(CTRL_W)
	) u_ctrl_drv (
		.sys_clk_in(sys_clk_in),
		.rst_in(rst_in),
		.latch_in(ctrl_latch_reg),
		.dir_in(ctrl_dir_reg),
		.force_out_in({CTRL_W{1'b0}}),
		.force_in_in({CTRL_W{1'b0}}),
		.alt_data_in(ctrl_latch_reg),
		.pin_out(ctrl_pin_out),
		.pin_oe_out(ctrl_pin_oe_out)
	);

	// Levels handed to peripherals and the slave transfer engine
	always_ff @(posedge sys_clk_in or posedge rst_in) begin
		if (rst_in) begin
			periph_pin_level_out <= 8'h00;
			slave_bus_level_out <= 8'h00;
			read_strobe_n_out <= 1'b1;
			write_strobe_n_out <= 1'b1;
			chip_select_n_out <= 1'b1;
		end else begin
			// Bit n feeds the peripheral that owns pin n
			periph_pin_level_out <= periph_sync;
			slave_bus_level_out <= slave_sync;
			// Strobes idle high whenever slave mode is off
			read_strobe_n_out <= !slave_mode_reg
				|| ctrl_sync[READ_STROBE_BIT];
			write_strobe_n_out <= !slave_mode_reg
				|| ctrl_sync[WRITE_STROBE_BIT];
			chip_select_n_out <= !slave_mode_reg
				|| ctrl_sync[CHIP_SELECT_BIT];
		end
	end

	// Software must pick digital and inputs before slave mode
	always_comb begin
		slave_mode_select_out = slave_mode_reg;
		slave_output_latch_out = slave_latch_reg;
		analog_select_out = analog_mask;
	end
endmodule
`default_nettype wire

/* verification/gpio_checker_assertions.sv */
`timescale 1ns/1ps
`default_nettype none
module gpio_checker (
	input wire logic sys_clk_in,
	input wire logic rst_in,
	input wire logic other_rst_in,
	input wire logic rd_en_in,
	input wire logic [gpio_pkg::DATA_W-1:0] rd_data_out,
	input wire logic [7:0] periph_pin_out,
	input wire logic [7:0] periph_pin_oe_out,
	input wire logic [7:0] periph_force_out_in,
	input wire logic [7:0] periph_force_in_in,
	input wire logic [7:0] periph_data_in,
	input wire logic [7:0] slave_pin_out,
	input wire logic [7:0] slave_pin_oe_out,
	input wire logic slave_mode_select_out,
	input wire logic read_strobe_n_out,
	input wire logic write_strobe_n_out,
	input wire logic chip_select_n_out,
	input wire logic slave_bus_drive_in,
	input wire logic [7:0] slave_output_latch_out,
	input wire logic [gpio_pkg::CTRL_W-1:0] analog_select_out
);
	import gpio_pkg::*;
	default clocking @(posedge sys_clk_in); endclocking
	default disable iff (rst_in);
	rd_idle_zero_a: assert property (!rd_en_in |=>
		rd_data_out == 8'h00) else $error("read data not zero");
	force_out_oe_a: assert property (periph_force_out_in != 8'h00
		|=> (periph_pin_oe_out & $past(periph_force_out_in))
		== $past(periph_force_out_in)) else $error("forced output off");
	force_in_oe_a: assert property (periph_force_in_in != 8'h00 |=>
		(periph_pin_oe_out & $past(periph_force_in_in)
		& ~$past(periph_force_out_in)) == 8'h00) else $error("forced input on");
	force_data_a: assert property (periph_force_out_in != 8'h00 |=>
		((periph_pin_out ^ $past(periph_data_in))
		& $past(periph_force_out_in)) == 8'h00) else $error("forced data");
	strobes_idle_a: assert property (!slave_mode_select_out
		&& !$past(slave_mode_select_out) |-> read_strobe_n_out
		&& write_strobe_n_out && chip_select_n_out) else $error("strobe low");
	slave_float_a: assert property (slave_mode_select_out
		&& !slave_bus_drive_in |=> slave_pin_oe_out == 8'h00)
		else $error("slave pins driven");
	slave_drive_a: assert property (slave_mode_select_out
		&& slave_bus_drive_in |=> slave_pin_oe_out == 8'hff
		&& slave_pin_out == $past(slave_output_latch_out))
		else $error("slave pins wrong");
	reset_state_a: assert property ($fell(rst_in) |->
		periph_pin_oe_out == 8'h00 && slave_pin_oe_out == 8'h00
		&& analog_select_out == 3'h7) else $error("reset state");
	warm_reset_a: assert property (other_rst_in |=>
		!slave_mode_select_out && analog_select_out == 3'h7
		##1 slave_pin_oe_out == 8'h00) else $error("warm reset state");
	mode_drive_c: cover property (slave_mode_select_out && slave_bus_drive_in);
	forced_c: cover property (periph_force_out_in != 8'h00);
	warm_c: cover property (other_rst_in);
endmodule
bind three_port_gpio_block gpio_checker chk (.*);
`default_nettype wire

/* verification/pin_world.sv */
`timescale 1ns/1ps
`default_nettype none
module pin_world #(
	parameter int WIDTH = 8
) (
	input wire logic [WIDTH-1:0] drv_in,
	input wire logic [WIDTH-1:0] oe_in,
	input wire logic [WIDTH-1:0] ext_in,
	output logic [WIDTH-1:0] level_out
);
	// Outside parts drive only the pins the block leaves floating
	assign level_out = (drv_in & oe_in) | (ext_in & ~oe_in);
endmodule
`default_nettype wire

/* verification/tb.sv */
`timescale 1ns/1ps
`default_nettype none
module tb;
	import gpio_pkg::*;
	logic sys_clk_in, rst_in, other_rst_in, wr_en_in, rd_en_in;
	logic [7:0] addr_in, wr_data_in, rd_data_out;
	logic [7:0] periph_pin_in, periph_pin_out, periph_pin_oe_out;
	logic [7:0] periph_force_out_in, periph_force_in_in, periph_data_in;
	logic [7:0] periph_pin_level_out, slave_pin_in, slave_pin_out;
	logic [7:0] slave_pin_oe_out, slave_bus_level_out, slave_input_latch_in;
	logic [7:0] slave_output_latch_out, periph_ext, slave_ext;
	logic [2:0] ctrl_pin_in, ctrl_pin_out, ctrl_pin_oe_out, analog_select_out;
	logic [2:0] ctrl_ext;
	logic slave_mode_select_out, read_strobe_n_out, write_strobe_n_out;
	logic chip_select_n_out, slave_bus_drive_in, word_received_in;
	logic word_taken_in;
	int failures, tests_run;
	three_port_gpio_block uut (.*);
	pin_world #(.WIDTH(8)) pw_p (.drv_in(periph_pin_out),
		.oe_in(periph_pin_oe_out), .ext_in(periph_ext),
		.level_out(periph_pin_in));
	pin_world #(.WIDTH(8)) pw_s (.drv_in(slave_pin_out),
		.oe_in(slave_pin_oe_out), .ext_in(slave_ext), .level_out(slave_pin_in));
	pin_world #(.WIDTH(3)) pw_c (.drv_in(ctrl_pin_out),
		.oe_in(ctrl_pin_oe_out), .ext_in(ctrl_ext), .level_out(ctrl_pin_in));
	initial begin
		sys_clk_in = 1'b0;
		forever #25 sys_clk_in = ~sys_clk_in;
	end
	task automatic check(input string name, input logic [7:0] seen, exp);
		tests_run++;
		if (seen !== exp) begin
			failures++;
			$display("Error %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task automatic wr(input logic [7:0] a, d);
		@(posedge sys_clk_in);
		addr_in <= a;
		wr_data_in <= d;
		wr_en_in <= 1'b1;
		@(posedge sys_clk_in);
		wr_en_in <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, exp);
		@(posedge sys_clk_in);
		addr_in <= a;
		rd_en_in <= 1'b1;
		@(posedge sys_clk_in);
		rd_en_in <= 1'b0;
		@(negedge sys_clk_in);
		check($sformatf("register %h", a), rd_data_out, exp);
	endtask
	task automatic settle;
		repeat (4) @(posedge sys_clk_in);
		@(negedge sys_clk_in);
	endtask
	task automatic engine(input logic rx, tk);
		@(posedge sys_clk_in);
		word_received_in <= rx;
		word_taken_in <= tk;
		@(posedge sys_clk_in);
		word_received_in <= 1'b0;
		word_taken_in <= 1'b0;
	endtask
	task automatic power_on;
		rst_in <= 1'b1;
		repeat (10) @(posedge sys_clk_in);
		rst_in <= 1'b0;
	endtask
	task automatic print_verdict;
		$display("Comparisons %0d mismatches %0d", tests_run, failures);
		if (failures == 0 && tests_run > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask
	initial begin
		repeat (20000) @(posedge sys_clk_in);
		failures++;
		print_verdict();
	end
	initial begin
		{rst_in, other_rst_in, wr_en_in, rd_en_in} = 4'h8;
		{addr_in, wr_data_in, periph_force_out_in, periph_force_in_in} = '0;
		{periph_data_in, slave_input_latch_in} = '0;
		{slave_bus_drive_in, word_received_in, word_taken_in} = '0;
		{periph_ext, slave_ext, ctrl_ext} = {8'h5a, 8'h3c, 3'h5};
		power_on();
		rd(PERIPH_DIR_ADDR, 8'hff);
		rd(SLAVE_DIR_ADDR, 8'hff);
		rd(CTRL_DIR_MODE_ADDR, 8'h07);
		rd(CTRL_DATA_ADDR, 8'h00); // Analog after power-on
		rd(8'h55, 8'h00); // Unmapped address
		wr(PERIPH_DATA_ADDR, 8'hc3);
		wr(PERIPH_DIR_ADDR, 8'h0f);
		settle();
		check("periph oe", periph_pin_oe_out, 8'hf0);
		check("periph pins", periph_pin_out & 8'hf0, 8'hc0);
		check("periph level", periph_pin_level_out, 8'hca);
		rd(PERIPH_DATA_ADDR, 8'hca);
		// Walk every pin role with one pin forced out and one forced in
		for (int i = 0; i < 8; i++) begin
			@(posedge sys_clk_in);
			periph_force_out_in <= 8'h01 << i;
			periph_force_in_in <= 8'h80 >> i;
			periph_data_in <= 8'h01 << i;
			settle();
			check("forced oe", periph_pin_oe_out,
				(8'hf0 | (8'h01 << i)) & ~(8'h80 >> i));
			check("forced pin", periph_pin_out & (8'h01 << i),
				8'h01 << i);
		end
		rd(PERIPH_DIR_ADDR, 8'h0f); // Stored value under override
		@(posedge sys_clk_in);
		periph_force_out_in <= 8'h00;
		periph_force_in_in <= 8'h00;
		// Whole-byte direction writes only, no bit edits
		wr(SLAVE_DATA_ADDR, 8'ha5);
		wr(SLAVE_DIR_ADDR, 8'h55);
		settle();
		check("slave oe", slave_pin_oe_out, 8'haa);
		rd(SLAVE_DATA_ADDR, 8'hb4);
		wr(ANALOG_CFG_ADDR, 8'h07);
		wr(CTRL_DIR_MODE_ADDR, 8'h06);
		wr(CTRL_DATA_ADDR, 8'h00);
		settle();
		check("analog select", analog_select_out, 3'h0);
		check("ctrl oe", ctrl_pin_oe_out, 3'h1);
		rd(CTRL_DATA_ADDR, 8'h04);
		wr(ANALOG_CFG_ADDR, 8'h00);
		settle();
		check("analog ctrl oe", ctrl_pin_oe_out, 3'h1);
		rd(CTRL_DATA_ADDR, 8'h00);
		wr(ANALOG_CFG_ADDR, 8'h07); // Digital inputs first
		wr(CTRL_DIR_MODE_ADDR, 8'h17);
		ctrl_ext <= 3'h2;
		settle();
		check("mode", slave_mode_select_out, 1'b1);
		check("strobes", {chip_select_n_out, write_strobe_n_out,
			read_strobe_n_out}, 3'h2);
		check("slave float", slave_pin_oe_out, 8'h00);
		wr(SLAVE_DATA_ADDR, 8'h69);
		slave_bus_drive_in <= 1'b1;
		rd(CTRL_DIR_MODE_ADDR, 8'h57); // Output word pending
		check("slave drive", slave_pin_out, 8'h69);
		engine(1'b0, 1'b1);
		slave_input_latch_in <= 8'h96;
		engine(1'b1, 1'b0);
		rd(CTRL_DIR_MODE_ADDR, 8'h97);
		check("slave bus", slave_bus_level_out, 8'h69);
		rd(SLAVE_DATA_ADDR, 8'h96);
		rd(CTRL_DIR_MODE_ADDR, 8'h17);
		engine(1'b1, 1'b0);
		engine(1'b1, 1'b0);
		rd(CTRL_DIR_MODE_ADDR, 8'hb7); // Overrun
		wr(SLAVE_DATA_ADDR, 8'h11);
		wr(CTRL_DIR_MODE_ADDR, 8'h27);
		rd(CTRL_DIR_MODE_ADDR, 8'h27); // Flags clear, overrun kept
		settle();
		check("idle strobes", {chip_select_n_out, write_strobe_n_out,
			read_strobe_n_out}, 3'h7);
		wr(PERIPH_DIR_ADDR, 8'h00);
		@(posedge sys_clk_in);
		other_rst_in <= 1'b1;
		@(posedge sys_clk_in);
		other_rst_in <= 1'b0;
		rd(CTRL_DIR_MODE_ADDR, 8'h07);
		rd(PERIPH_DIR_ADDR, 8'hff);
		rd(SLAVE_DIR_ADDR, 8'hff);
		wr(PERIPH_DIR_ADDR, 8'h00);
		settle();
		rd(PERIPH_DATA_ADDR, 8'hc3); // Latch survives warm reset
		@(posedge sys_clk_in);
		power_on();
		rd(CTRL_DIR_MODE_ADDR, 8'h07);
		rd(CTRL_DATA_ADDR, 8'h00);
		print_verdict();
	end
endmodule
`default_nettype wire
